// ==== src/key_event_power_control.sv ====
/*
  Key event and system power control register block: debounces the
  application keys and the power key, latches key events into write-zero
  flags, drives the key interrupt request and the system power state.
  Assumes key and dip inputs are synchronous to mclk and that the register
  master follows the one-cycle strobe protocol.
*/
`default_nettype none

module key_event_power_control
  import key_event_power_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire reg_req_s busReq,
  output logic [15:0] readData,
  input wire keys_s keys,
  input wire logic autoPowerDip,
  output logic systemPowerOn,
  output logic keyIrq
);

  // sample clock
  logic [31:0] tickCount;
  logic tick;

  // debounce history and accepted samples
  logic [7:0] rawKeys;
  logic [7:0] sampleA;
  logic [7:0] sampleB;
  logic [7:0] stableKeys;
  logic agree;

  // application key events
  logic [6:0] newApp;
  logic [6:0] oldApp;
  logic appChange;
  logic pressEvt;
  logic releaseEvt;
  logic multiHeld;
  logic keepPattern;
  logic [15:0] newPattern;

  // repeat and long press
  logic [5:0] repeatTicks;
  logic [5:0] repeatLimit;
  logic repeatEvt;
  logic [7:0] longTicks;
  logic longDone;
  logic longEvt;
  logic powerHeld;

  // registers
  logic [7:0] keyIrqControl;
  logic [7:0] repeatIntervalSelect;
  logic [7:0] keyEventStatus;
  logic [15:0] keyPattern;
  logic keySummaryFlag;
  logic offSourceSelect;
  power_state_e powerState;
  power_state_e next_powerState;
  logic startupDone;

  // decode
  logic wrControl;
  logic wrRepeat;
  logic wrStatus;
  logic wrPower;
  logic wrSource;
  logic wrSummary;
  logic [7:0] flagSet;
  logic [7:0] flagClear;
  logic [7:0] next_keyEventStatus;
  logic summaryClear;
  logic next_keySummaryFlag;
  logic [15:0] readMux;

  // interval in sample ticks for the lowest selected one-hot bit
  function automatic logic [5:0] repeat_ticks(input logic [7:0] sel);
    logic [5:0] result;
    result = 6'(REPEAT_BASE_MS / SAMPLE_PERIOD_MS);
    for (int i = REPEAT_CHOICES - 1; i >= 0; i--) begin
      if (sel[i]) begin
        result = 6'((REPEAT_BASE_MS + REPEAT_STEP_MS * i) / SAMPLE_PERIOD_MS);
      end
    end
    return result;
  endfunction : repeat_ticks

  // sample tick every SAMPLE_CYCLES clocks
  assign tick = (tickCount == 32'(SAMPLE_CYCLES - 1)); // [R18]

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tickCount <= '0;
    end else if (tick) begin
      tickCount <= '0;
    end else begin
      tickCount <= tickCount + 32'h00000001;
    end
  end

  assign rawKeys = {keys.powerOn, keys.secondButton, keys.thirdButton, keys.cursorOrPowerSwitch};

  // a new value is accepted only when the current and two previous samples match
  assign agree = tick && (rawKeys == sampleA) && (sampleA == sampleB); // [R18]

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sampleA <= '0;
      sampleB <= '0;
      stableKeys <= '0;
    end else begin
      if (tick) begin
        sampleA <= rawKeys;
        sampleB <= sampleA;
      end
      if (agree) begin
        stableKeys <= rawKeys; // [R18]
      end
    end
  end

  assign newApp = rawKeys[6:0];
  assign oldApp = stableKeys[6:0];
  assign appChange = agree && (newApp != oldApp);
  // one event covers however many keys changed in the same sample
  assign pressEvt = appChange && (newApp != 7'h00); // [R03] [R08] [R09]
  assign releaseEvt = appChange && ((oldApp & ~newApp) != 7'h00); // [R04] [R10]
  assign multiHeld = (oldApp & (oldApp - 7'h01)) != 7'h00;
  // a single key release clears its bit; a multi-key release to nothing keeps the pattern
  assign keepPattern = (newApp == 7'h00) && multiHeld; // [R11]

  always_comb begin
    newPattern = KEY_PATTERN_RESET;
    newPattern[PAT_CURSOR_LSB +: RAW_CURSOR_WIDTH] = newApp[RAW_CURSOR_WIDTH-1:0]; // [R01]
    newPattern[PAT_THIRD] = newApp[RAW_THIRD]; // [R01]
    newPattern[PAT_SECOND] = newApp[RAW_SECOND]; // [R01]
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      keyPattern <= KEY_PATTERN_RESET; // [R02]
    end else if (appChange && !keepPattern) begin
      keyPattern <= newPattern; // [R02]
    end
  end

  // auto repeat counts sample ticks while the same pattern stays held
  assign repeatLimit = repeat_ticks(repeatIntervalSelect); // [R20]
  assign repeatEvt = tick && !appChange && (oldApp != 7'h00) && (repeatTicks == repeatLimit - 6'h01); // [R05]

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      repeatTicks <= '0;
    end else if (appChange || (oldApp == 7'h00) || repeatEvt) begin
      repeatTicks <= '0;
    end else if (tick) begin
      repeatTicks <= repeatTicks + 6'h01;
    end
  end

  // long press fires once per hold of the debounced power key
  assign powerHeld = stableKeys[RAW_POWER];
  assign longEvt = tick && powerHeld && !longDone && (longTicks == LONG_PRESS_TICKS - 8'h01); // [R06]

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      longTicks <= '0;
      longDone <= 1'b0;
    end else if (!powerHeld) begin
      longTicks <= '0;
      longDone <= 1'b0;
    end else if (longEvt) begin
      longDone <= 1'b1;
    end else if (tick && !longDone) begin
      longTicks <= longTicks + 8'h01;
    end
  end

  // register write decode
  assign wrControl = busReq.wr && (busReq.addr == ADDR_KEY_IRQ_CONTROL);
  assign wrRepeat = busReq.wr && (busReq.addr == ADDR_REPEAT_INTERVAL_SELECT);
  assign wrStatus = busReq.wr && (busReq.addr == ADDR_KEY_EVENT_STATUS);
  assign wrPower = busReq.wr && (busReq.addr == ADDR_SYSTEM_POWER_CONTROL);
  assign wrSource = busReq.wr && (busReq.addr == ADDR_POWER_OFF_SOURCE);
  assign wrSummary = busReq.wr && (busReq.addr == ADDR_SHARED_EVENT_SUMMARY);

  always_comb begin
    flagSet = 8'h00;
    flagSet[BIT_PRESS] = pressEvt; // [R03]
    flagSet[BIT_RELEASE] = releaseEvt; // [R04]
    flagSet[BIT_REPEAT] = repeatEvt; // [R05]
    flagSet[BIT_LONG_PRESS] = longEvt; // [R06]
  end

  // only a written zero over a set flag clears it; a new event in that cycle wins
  assign flagClear = wrStatus ? (~busReq.wdata[7:0] & keyEventStatus) : 8'h00; // [R07]
  assign next_keyEventStatus = ((keyEventStatus & ~flagClear) | flagSet) & KEY_FLAG_MASK; // [R07]

  assign summaryClear = wrSummary && !busReq.wdata[BIT_SUMMARY] && keySummaryFlag; // [R12]
  // summary cannot drop while any key flag stays set
  assign next_keySummaryFlag = (|next_keyEventStatus) | (keySummaryFlag & ~summaryClear); // [R12]

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      keyEventStatus <= KEY_STATUS_RESET;
      keySummaryFlag <= 1'b0;
    end else begin
      keyEventStatus <= next_keyEventStatus;
      keySummaryFlag <= next_keySummaryFlag;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      keyIrqControl <= KEY_IRQ_CONTROL_RESET; // [R19]
      repeatIntervalSelect <= REPEAT_SELECT_RESET; // [R20]
      offSourceSelect <= OFF_SOURCE_RESET; // [R17]
    end else begin
      if (wrControl) begin
        keyIrqControl <= busReq.wdata[7:0] & KEY_CONTROL_MASK; // [R19]
      end
      if (wrRepeat) begin
        repeatIntervalSelect <= busReq.wdata[7:0]; // [R20]
      end
      if (wrSource) begin
        offSourceSelect <= busReq.wdata[BIT_OFF_SOURCE]; // [R17]
      end
    end
  end

  // power state: while on, host writes take priority over a long press in the same cycle
  always_comb begin
    next_powerState = powerState;
    case (powerState)
      PWR_OFF: begin
        if (!startupDone && autoPowerDip) begin
          next_powerState = PWR_ON; // [R15]
        end else if (wrPower && busReq.wdata[BIT_POWER_ON]) begin
          next_powerState = PWR_ON; // [R16]
        end else if (longEvt) begin
          next_powerState = PWR_ON; // [R13]
        end
      end
      PWR_ON: begin
        if (wrPower) begin
          if (!busReq.wdata[BIT_POWER_ON] && (offSourceSelect == OFF_SOURCE_HOST)) begin
            next_powerState = PWR_OFF; // [R14] [R16]
          end
        end else if (longEvt && (offSourceSelect != OFF_SOURCE_HOST)) begin
          next_powerState = PWR_OFF; // [R17]
        end
      end
      default: begin
        next_powerState = PWR_ON;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      powerState <= POWER_ON_RESET ? PWR_ON : PWR_OFF; // [R16]
      startupDone <= 1'b0;
    end else begin
      powerState <= next_powerState;
      startupDone <= 1'b1;
    end
  end

  assign systemPowerOn = (powerState == PWR_ON);

  // read multiplexer; unmapped addresses and reserved bits read zero
  assign readMux =
    (busReq.addr == ADDR_KEY_IRQ_CONTROL) ? {8'h00, keyIrqControl} :
    (busReq.addr == ADDR_REPEAT_INTERVAL_SELECT) ? {8'h00, repeatIntervalSelect} :
    (busReq.addr == ADDR_KEY_EVENT_STATUS) ? {8'h00, keyEventStatus} : // [R07]
    (busReq.addr == ADDR_KEY_PATTERN) ? keyPattern : // [R01]
    (busReq.addr == ADDR_SYSTEM_POWER_CONTROL) ? {15'h0000, systemPowerOn} : // [R16]
    (busReq.addr == ADDR_POWER_OFF_SOURCE) ? {15'h0000, offSourceSelect} : // [R17]
    (busReq.addr == ADDR_SHARED_EVENT_SUMMARY) ? 16'(keySummaryFlag) << BIT_SUMMARY : // [R12]
    16'h0000;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      readData <= 16'h0000;
      keyIrq <= 1'b0;
    end else begin
      readData <= busReq.rd ? readMux : 16'h0000;
      // request holds while any enabled flag stays set
      keyIrq <= |(keyEventStatus & keyIrqControl & KEY_FLAG_MASK); // [R21] [R03] [R04] [R05] [R06]
    end
  end

endmodule : key_event_power_control

`default_nettype wire

// ==== src/key_event_power_pkg.sv ====
/*
  Constants, register map, field positions, timing and carrier types for the
  key event and power control register block.
  Assumes a 100 MHz controller clock and a byte-addressed register port.

  // What this block does
  // [R01] read-only 16-bit key pattern, fixed bit placement
  // [R02] pattern bit one while key judged pressed
  // [R03] key press sets press flag, may interrupt
  // [R04] key release sets release flag, may interrupt
  // [R05] held key sets repeat flag each interval
  // [R06] power key held two seconds sets flag
  // [R07] flags clear on written zero only
  // [R08] simultaneous presses give one press event
  // [R09] any held pattern change gives press event
  // [R10] releasing several held keys gives release event
  // [R11] multi-key release keeps previous pattern
  // [R12] summary bit mirrors flags, cleared by zero
  // [R13] long power press switches system on
  // [R14] host may switch system off
  // [R15] auto-power switch powers system at startup
  // [R16] power control bit, resets to on
  // [R17] off source select, resets to switch
  // [R18] sample every 10 ms, three agreeing samples
  // [R19] interrupt enables in control bits one..four
  // [R20] one-hot repeat interval 100..450 ms
  // [R21] interrupt is OR of enabled flags
*/
`default_nettype none

package key_event_power_pkg;

  localparam logic [7:0] ADDR_KEY_IRQ_CONTROL = 8'h60;
  localparam logic [7:0] ADDR_REPEAT_INTERVAL_SELECT = 8'h61;
  localparam logic [7:0] ADDR_KEY_EVENT_STATUS = 8'h62;
  localparam logic [7:0] ADDR_KEY_PATTERN = 8'h64;
  localparam logic [7:0] ADDR_SYSTEM_POWER_CONTROL = 8'h70;
  localparam logic [7:0] ADDR_POWER_OFF_SOURCE = 8'h71;
  localparam logic [7:0] ADDR_SHARED_EVENT_SUMMARY = 8'h90;

  // status flag and interrupt enable positions share one layout
  localparam int BIT_PRESS = 1;
  localparam int BIT_RELEASE = 2;
  localparam int BIT_REPEAT = 3;
  localparam int BIT_LONG_PRESS = 4;
  localparam int BIT_SUMMARY = 2;
  localparam int BIT_POWER_ON = 0;
  localparam int BIT_OFF_SOURCE = 0;
  localparam logic [7:0] KEY_FLAG_MASK = 8'h1E;
  localparam logic [7:0] KEY_CONTROL_MASK = 8'h3E;

  // key pattern placement
  localparam int PAT_CURSOR_LSB = 0;
  localparam int PAT_THIRD = 8;
  localparam int PAT_SECOND = 10;

  // raw sample vector placement
  localparam int RAW_CURSOR_WIDTH = 5;
  localparam int RAW_THIRD = 5;
  localparam int RAW_SECOND = 6;
  localparam int RAW_POWER = 7;

  localparam logic [7:0] KEY_IRQ_CONTROL_RESET = 8'h20;
  localparam logic [7:0] REPEAT_SELECT_RESET = 8'h01;
  localparam logic [7:0] KEY_STATUS_RESET = 8'h00;
  localparam logic [15:0] KEY_PATTERN_RESET = 16'h0000;
  localparam logic POWER_ON_RESET = 1'b1;
  localparam logic OFF_SOURCE_RESET = 1'b1;
  localparam logic OFF_SOURCE_HOST = 1'b0;

  localparam int CLOCK_MHZ = 100;
  localparam int SAMPLE_PERIOD_MS = 10;
  localparam int SAMPLE_CYCLES_DEFAULT = SAMPLE_PERIOD_MS * 1000 * CLOCK_MHZ;
  localparam int LONG_PRESS_MS = 2000;
  localparam logic [7:0] LONG_PRESS_TICKS = 8'(LONG_PRESS_MS / SAMPLE_PERIOD_MS);
  localparam int REPEAT_BASE_MS = 100;
  localparam int REPEAT_STEP_MS = 50;
  localparam int REPEAT_CHOICES = 8;

  typedef enum logic [1:0] {
    PWR_OFF = 2'b01,
    PWR_ON = 2'b10
  } power_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic powerOn;
    logic thirdButton;
    logic secondButton;
    logic [4:0] cursorOrPowerSwitch;
  } keys_s;

endpackage : key_event_power_pkg

`default_nettype wire

// ==== tb/key_event_power_chk.sv ====
/*
  Port checker for the key event and power control block.
  Assumes one clock domain and a bind onto every block instance.
*/
`default_nettype none
module key_event_power_chk
  import key_event_power_pkg::*;
#(
  parameter int SAMPLE_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire reg_req_s busReq,
  input wire logic [15:0] readData,
  input wire keys_s keys,
  input wire logic autoPowerDip,
  input wire logic systemPowerOn,
  input wire logic keyIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  idle_data_zero_a: assert property (!$past(busReq.rd) |-> readData == 16'h0000)
    else $error("read data not zero when idle");
  pattern_zero_bits_a: assert property ($past(busReq.rd && busReq.addr == ADDR_KEY_PATTERN)
    |-> (readData & 16'hFAE0) == 16'h0000) else $error("key pattern spare bits set");
  status_zero_bits_a: assert property ($past(busReq.rd && busReq.addr == ADDR_KEY_EVENT_STATUS)
    |-> (readData & 16'hFFE1) == 16'h0000) else $error("status spare bits set");
  power_readback_a: assert property ($past(busReq.rd && busReq.addr == ADDR_SYSTEM_POWER_CONTROL)
    |-> readData == {15'h0000, $past(systemPowerOn)}) else $error("power bit differs from pin");
  source_zero_bits_a: assert property ($past(busReq.rd && busReq.addr == ADDR_POWER_OFF_SOURCE)
    |-> readData[15:1] == 15'h0000) else $error("off source spare bits set");
  summary_zero_bits_a: assert property ($past(busReq.rd && busReq.addr == ADDR_SHARED_EVENT_SUMMARY)
    |-> (readData & 16'hFFFB) == 16'h0000) else $error("summary spare bits set");
  // an interrupt can only drop after a flag clear or an enable write
  irq_fall_cause_a: assert property ($fell(keyIrq) |-> $past(busReq.wr) || $past(busReq.wr, 2))
    else $error("interrupt dropped without a write");
  power_off_cause_a: assert property ($fell(systemPowerOn)
    |-> $past(busReq.wr) || $past(busReq.wr, 2) || $past(keys.powerOn, 2)) else $error("power lost by itself");
  power_on_cause_a: assert property ($rose(systemPowerOn)
    |-> $past(busReq.wr) || $past(busReq.wr, 2) || $past(keys.powerOn, 2)) else $error("power up by itself");
endmodule : key_event_power_chk

bind key_event_power_control key_event_power_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_key_event_power_chk (
  .mclk(mclk), .rst_n(rst_n), .busReq(busReq), .readData(readData), .keys(keys),
  .autoPowerDip(autoPowerDip), .systemPowerOn(systemPowerOn), .keyIrq(keyIrq));
`default_nettype wire

// ==== tb/key_switch_model.sv ====
/*
  Board switch model: drives the key lines from a wanted state, optionally chattering.
  Assumes the same clock as the block.
*/
`default_nettype none
module key_switch_model
  import key_event_power_pkg::*;
(
  input wire logic mclk,
  input wire keys_s want,
  input wire logic chatter,
  output var keys_s keys
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt = 3'h0;
  logic flip = 1'b0;
  // period ten never lines up with a four-cycle sample tick
  always @(posedge mclk) begin
    cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
    if (cnt == 3'h4) flip <= ~flip;
  end
  assign keys = want ^ {7'h00, chatter & flip};
endmodule : key_switch_model
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for the key event and power control block.
  Assumes a sample tick every four clocks, set by the parameter below.
*/
`default_nettype none
module tb_top
  import key_event_power_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic autoPowerDip = 1'b0;
  logic chatter = 1'b0;
  reg_req_s busReq = '0;
  keys_s want = '0;
  keys_s keys, k, k2;
  logic [15:0] readData, got;
  logic systemPowerOn, keyIrq;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 37228;
  always #5 mclk = ~mclk;
  key_event_power_control #(.SAMPLE_CYCLES(4)) i_key_event_power_control (.mclk(mclk), .rst_n(rst_n),
    .busReq(busReq), .readData(readData), .keys(keys), .autoPowerDip(autoPowerDip),
    .systemPowerOn(systemPowerOn), .keyIrq(keyIrq));
  key_switch_model i_key_switch_model (.mclk(mclk), .want(want), .chatter(chatter), .keys(keys));
  function automatic logic [15:0] patOf(keys_s s);
    patOf = {5'h00, s.secondButton, 1'b0, s.thirdButton, 3'h0, s.cursorOrPowerSwitch};
  endfunction : patOf
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // pins are read just after the edge so that this edge's update is seen, then the bench realigns
  task automatic chkPin(input logic pickPower, input logic e);
    #1 chk({15'h0000, pickPower ? systemPowerOn : keyIrq}, {15'h0000, e});
    @(posedge mclk);
  endtask : chkPin
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    busReq <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge mclk);
    busReq <= '0;
    #1 got = readData;
    @(posedge mclk);
  endtask : acc
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk(got, e);
  endtask : rdc
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask : settle
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  logic [7:0] ra [8] = '{8'h60, 8'h61, 8'h62, 8'h64, 8'h70, 8'h71, 8'h90, 8'h80};
  logic [15:0] rv [8] = '{16'h0020, 16'h0001, 16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000};
  initial begin
    settle(5);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(ra[i], rv[i]);
    $display("test reset values done");
    // long repeat interval keeps repeat events out of the press checks
    acc(1'b1, 8'h61, 16'h0080);
    acc(1'b1, 8'h60, 16'h003E);
    k = 8'($random(seed));
    k.powerOn = 1'b0;
    k.cursorOrPowerSwitch[2:0] = 3'h7;
    want <= k;
    settle(20);
    rdc(8'h64, patOf(k));
    rdc(8'h62, 16'h0002);
    rdc(8'h90, 16'h0004);
    chkPin(1'b0, 1'b1);
    acc(1'b1, 8'h62, 16'h00FF);
    rdc(8'h62, 16'h0002);
    acc(1'b1, 8'h62, 16'h0000);
    rdc(8'h62, 16'h0000);
    k2 = k;
    k2.cursorOrPowerSwitch[0] = 1'b0;
    want <= k2;
    settle(20);
    rdc(8'h64, patOf(k2));
    rdc(8'h62, 16'h0006);
    acc(1'b1, 8'h90, 16'h0000);
    rdc(8'h90, 16'h0004);
    acc(1'b1, 8'h62, 16'h0000);
    acc(1'b1, 8'h90, 16'h0000);
    rdc(8'h90, 16'h0000);
    want <= '0;
    settle(20);
    rdc(8'h64, patOf(k2));
    rdc(8'h62, 16'h0004);
    acc(1'b1, 8'h62, 16'h0000);
    $display("test key events done");
    chatter <= 1'b1;
    settle(60);
    rdc(8'h62, 16'h0000);
    chatter <= 1'b0;
    $display("test chatter done");
    acc(1'b1, 8'h61, 16'h0002);
    want <= k;
    settle(20);
    acc(1'b1, 8'h62, 16'h0000);
    settle(56);
    rdc(8'h62, 16'h0008);
    chkPin(1'b0, 1'b1);
    acc(1'b1, 8'h60, 16'h0020);
    chkPin(1'b0, 1'b0);
    // a shorter interval would have repeated again before this read
    acc(1'b1, 8'h62, 16'h0000);
    settle(8);
    rdc(8'h62, 16'h0000);
    settle(40);
    rdc(8'h62, 16'h0008);
    want <= '0;
    settle(20);
    acc(1'b1, 8'h62, 16'h0000);
    $display("test repeat done");
    acc(1'b1, 8'h70, 16'h0000);
    chkPin(1'b1, 1'b1);
    acc(1'b1, 8'h71, 16'h0000);
    acc(1'b1, 8'h70, 16'h0000);
    chkPin(1'b1, 1'b0);
    rdc(8'h70, 16'h0000);
    k = '0;
    k.powerOn = 1'b1;
    want <= k;
    settle(830);
    chkPin(1'b1, 1'b1);
    rdc(8'h62, 16'h0010);
    want <= '0;
    $display("test power done");
    autoPowerDip <= 1'b1;
    acc(1'b1, 8'h70, 16'h0000);
    rst_n <= 1'b0;
    settle(5);
    rst_n <= 1'b1;
    settle(2);
    chkPin(1'b1, 1'b1);
    $display("test auto power done");
    results();
  end
  initial begin
    settle(5000);
    mismatches++;
    $display("mismatch %0t watchdog expired", $time);
    results();
  end
endmodule : tb_top
`default_nettype wire
